// File: amcal_pkg.sv
/*
  Shared constants for the AM modulation depth calibration pair:
  device register map, direct command codes, field positions, timing
  and the target level divider.
  Assumes both ends and the bench compile this package first.
*/
package amcal_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TX_SETTLE_NS  = 1000;
  // Least time, so round up
  localparam int TX_SETTLE_CYC = (TX_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  //////////////////////////////////////////////////////////////////////////////
  // Device link and registers
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;

  localparam logic [5:0] REG_OPCTL      = 6'h00;
  localparam logic [5:0] REG_AUX        = 6'h01;
  localparam logic [5:0] REG_DEPTH_CTRL = 6'h02;
  localparam logic [5:0] REG_DEPTH_DISP = 6'h03;
  localparam logic [5:0] REG_MOD_LEVEL  = 6'h04;
  localparam logic [5:0] REG_NORM_LEVEL = 6'h05;
  localparam logic [5:0] REG_ADC_OUT    = 6'h06;
  localparam logic [5:0] REG_CMD        = 6'h07;

  localparam int OPCTL_TX_BIT     = 0;
  localparam int AUX_AM_BIT       = 0;
  localparam int DEPTH_MANUAL_BIT = 7;
  localparam int DEPTH_RATIO_LSB  = 1;
  localparam int RATIO_W          = 6;

  localparam logic [7:0] CMD_CAL_DEPTH = 8'h01;
  localparam logic [7:0] CMD_MEASURE   = 8'h02;

  localparam logic [7:0] BYTE_ZERO      = 8'h00;
  localparam logic [7:0] SAR_FIRST_MASK = 8'h80;
  localparam logic [7:0] SAR_LAST_MASK  = 8'h01;
  localparam logic [7:0] SEG_ALL_OFF    = 8'h00;
  localparam logic [8:0] DIV_ONE        = 9'h040;

  //////////////////////////////////////////////////////////////////////////////
  // Controller APB registers
  localparam logic [7:0] HREG_CTRL   = 8'h00;
  localparam logic [7:0] HREG_CFG    = 8'h04;
  localparam logic [7:0] HREG_STATUS = 8'h08;
  localparam logic [7:0] HREG_RESULT = 8'h0C;

  localparam logic [1:0] OP_NONE   = 2'h0;
  localparam logic [1:0] OP_AUTO   = 2'h1;
  localparam logic [1:0] OP_EXT    = 2'h2;
  localparam logic [1:0] OP_MANUAL = 2'h3;

  localparam int CFG_RATIO_LSB = 0;
  localparam int CFG_FRAC_LSB  = 8;
  localparam int CFG_LEVEL_LSB = 16;
  localparam int CFG_AM_BIT    = 24;
  localparam logic [31:0] CFG_MASK = 32'h01FF_FF3F;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // Level divided by 1.ffffff (frac is sixty-fourths, up to eight bits)
  function automatic logic [7:0] amcal_target(input logic [7:0] meas,
                                              input logic [7:0] frac);
    logic [13:0] num;
    logic [13:0] den;
    logic [13:0] quo;
    num = {meas, 6'h00};
    den = {5'h00, DIV_ONE + {1'b0, frac}};
    quo = num / den;
    return quo[7:0];
  endfunction

endpackage

// File: amcal_link_if.sv
/*
  Link between the controller and the calibration device: register
  access with request/acknowledge and a busy level for direct commands.
  Assumes one common clock; the bench instantiates and joins both ends.
*/
`timescale 1ns/1ps
interface amcal_link_if;
  logic                          req;
  logic                          we;
  logic [amcal_pkg::ADDR_W-1:0]  addr;
  logic [amcal_pkg::DATA_W-1:0]  wdata;
  logic [amcal_pkg::DATA_W-1:0]  rdata;
  logic                          ack;
  logic                          busy;

  modport device (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output rdata,
    output ack,
    output busy
  );

  modport controller (
    output req,
    output we,
    output addr,
    output wdata,
    input  rdata,
    input  ack,
    input  busy
  );
endinterface

// File: amcal_device.sv
/*
  Device end: depth registers, calibrate and measure commands,
  successive approximation of driver strength, segment drive.
  Assumes A/D converter, modulator and bench share CLK; link via amcal_link_if.
*/
// Our own choices: the APB slave port and the placing of the registers.
// How it works
// - Manual select zero means command-defined level
// - Bits six to one hold ratio
// - Target is measurement divided by 1.ratio
// - Ratio 001110 gives about ten percent
// - Command first enables transmitter, unmodulated drive
// - Measure carrier, store in converter output
// - Derive target before driver adjustment
// - Successive approximation toward target amplitude
// - Search result goes to display register
// - Eight binary segments, normal level disables
// - Oscillator and regulators on before command
// - Leave normal level alone after calibration
// - Antenna calibration precedes depth calibration
// - Manual select one uses written level
// - Beyond 33 percent controller calibrates itself
// - External: zero normal, tx on, measure
// - External: vary normal, remeasure, compare
// - External: store best, restore normal
// - Auxiliary bit picks AM or on-off keying
`timescale 1ns/1ps
module amcal_device #(
  parameter logic [3:0] SETTLE_CYC = 4'(amcal_pkg::TX_SETTLE_CYC)
) (
  input  wire logic                         CLK,
  input  wire logic                         RESET_N,
  amcal_link_if.device                      LINK,
  input  wire logic                         MOD_IN,
  input  wire logic                         ADC_DONE,
  input  wire logic [amcal_pkg::DATA_W-1:0] SENSE_AMPLITUDE,
  output logic                              ADC_START,
  output logic                              TX_ENABLE,
  output logic                              AM_VERSUS_OOK_SELECT,
  output logic      [amcal_pkg::DATA_W-1:0] ANTENNA_DRIVER_ONE_SEG,
  output logic      [amcal_pkg::DATA_W-1:0] ANTENNA_DRIVER_TWO_SEG
);
  import amcal_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic [2:0] {
    D_IDLE,
    D_SETTLE,
    D_BASE_WAIT,
    D_CALC,
    D_SAR_STEP,
    D_SAR_WAIT,
    D_MEAS_WAIT
  } amcal_dstate_t;

  typedef struct packed {
    amcal_dstate_t st;
    logic          ack;
    logic          busy;
    logic [7:0]    rdata;
    logic          tx_on;
    logic          cal_tx;
    logic          am_sel;
    logic [7:0]    depth_ctrl;
    logic [7:0]    depth_disp;
    logic [7:0]    mod_level;
    logic [7:0]    norm_level;
    logic [7:0]    adc_out;
    logic [7:0]    target;
    logic [7:0]    result;
    logic [7:0]    apply;
    logic [7:0]    mask;
    logic [3:0]    cnt;
    logic          adc_start;
    logic          tx;
    logic [7:0]    seg;
  } amcal_dev_t;

  amcal_dev_t q;
  amcal_dev_t d;

  function automatic logic [7:0] dev_read(input amcal_dev_t s, input logic [5:0] a);
    logic [7:0] v;
    v = BYTE_ZERO;
    case (a)
      REG_OPCTL:      v[OPCTL_TX_BIT] = s.tx_on;
      REG_AUX:        v[AUX_AM_BIT] = s.am_sel;
      REG_DEPTH_CTRL: v = s.depth_ctrl;
      REG_DEPTH_DISP: v = s.depth_disp;
      REG_MOD_LEVEL:  v = s.mod_level;
      REG_NORM_LEVEL: v = s.norm_level;
      REG_ADC_OUT:    v = s.adc_out;
      default:        v = BYTE_ZERO;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [7:0] lvl;
    logic       keep;
    logic [7:0] nres;
    lvl  = BYTE_ZERO;
    keep = 1'b0;
    nres = BYTE_ZERO;
    d = q;
    d.ack = 1'b0;
    d.adc_start = 1'b0;

    // Register access, one acknowledge per request
    if (LINK.req && !q.ack)
    begin
      d.ack = 1'b1;
      d.rdata = dev_read(q, LINK.addr);
      if (LINK.we)
      begin
        case (LINK.addr)
          REG_OPCTL:      d.tx_on = LINK.wdata[OPCTL_TX_BIT];
          REG_AUX:        d.am_sel = LINK.wdata[AUX_AM_BIT];
          // Bit 0 reserved, reads zero
          REG_DEPTH_CTRL: d.depth_ctrl = {LINK.wdata[7:1], 1'b0};
          REG_MOD_LEVEL:  d.mod_level = LINK.wdata;
          REG_NORM_LEVEL: d.norm_level = LINK.wdata;
          REG_CMD:
          begin
            // Commands while busy are dropped, not queued
            if (q.st == D_IDLE && LINK.wdata == CMD_CAL_DEPTH)
            begin
              d.busy = 1'b1;
              d.cal_tx = 1'b1;
              d.cnt = 4'h0;
              d.st = D_SETTLE;
            end
            else if (q.st == D_IDLE && LINK.wdata == CMD_MEASURE)
            begin
              d.busy = 1'b1;
              d.adc_start = 1'b1;
              d.st = D_MEAS_WAIT;
            end
          end
          default: ;
        endcase
      end
    end

    unique case (q.st)
      D_IDLE: ;
      D_SETTLE:
      begin
        // Carrier must settle before the reference sample
        if (q.cnt >= SETTLE_CYC - 4'h1)
        begin
          d.adc_start = 1'b1;
          d.st = D_BASE_WAIT;
        end
        else
        begin
          d.cnt = q.cnt + 4'h1;
        end
      end
      D_BASE_WAIT:
      begin
        if (ADC_DONE)
        begin
          d.adc_out = SENSE_AMPLITUDE;
          d.st = D_CALC;
        end
      end
      D_CALC:
      begin
        d.target = amcal_target(q.adc_out,
                                {2'b00, q.depth_ctrl[DEPTH_RATIO_LSB +: RATIO_W]});
        d.result = BYTE_ZERO;
        d.mask = SAR_FIRST_MASK;
        d.st = D_SAR_STEP;
      end
      D_SAR_STEP:
      begin
        d.apply = q.result | q.mask;
        d.adc_start = 1'b1;
        d.st = D_SAR_WAIT;
      end
      D_SAR_WAIT:
      begin
        if (ADC_DONE)
        begin
          // Higher code means weaker drive; keep while still at or above target
          keep = SENSE_AMPLITUDE >= q.target;
          nres = keep ? q.apply : q.result;
          d.result = nres;
          d.mask = q.mask >> 1;
          if (q.mask == SAR_LAST_MASK)
          begin
            d.depth_disp = nres;
            d.cal_tx = 1'b0;
            d.busy = 1'b0;
            d.st = D_IDLE;
          end
          else
          begin
            d.st = D_SAR_STEP;
          end
        end
      end
      D_MEAS_WAIT:
      begin
        if (ADC_DONE)
        begin
          d.adc_out = SENSE_AMPLITUDE;
          d.busy = 1'b0;
          d.st = D_IDLE;
        end
      end
    endcase

    // Segment drive; a set bit in a level disables that segment
    lvl = d.norm_level;
    d.seg = ~lvl;
    if (d.st == D_SAR_WAIT || d.st == D_SAR_STEP)
    begin
      d.seg = ~d.apply;
    end
    else if (d.st == D_IDLE && MOD_IN)
    begin
      if (d.am_sel)
      begin
        lvl = d.depth_ctrl[DEPTH_MANUAL_BIT] ? d.mod_level : d.depth_disp;
        d.seg = ~lvl;
      end
      else
      begin
        d.seg = SEG_ALL_OFF;
      end
    end
    d.tx = d.tx_on | d.cal_tx;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign LINK.ack               = q.ack;
  assign LINK.rdata             = q.rdata;
  assign LINK.busy              = q.busy;
  assign ADC_START              = q.adc_start;
  assign TX_ENABLE              = q.tx;
  assign AM_VERSUS_OOK_SELECT   = q.am_sel;
  // Both drivers share one setting
  assign ANTENNA_DRIVER_ONE_SEG = q.seg;
  assign ANTENNA_DRIVER_TWO_SEG = q.seg;

endmodule

// File: amcal_host.sv
/*
  Controller end: APB slave with command, config, status and result
  words; sequences automatic, external and manual depth setup over the link.
  Assumes one clock with the device; the bench is the APB master.
*/
`timescale 1ns/1ps
module amcal_host (
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  amcal_link_if.controller LINK
);
  import amcal_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic [4:0] {
    H_IDLE, H_AUX, H_A_DEPTH, H_A_TXON, H_A_CMD, H_A_WAIT, H_A_READ,
    H_E_NORM0, H_E_TXON, H_E_CMD, H_E_WAIT, H_E_READ, H_E_TRY,
    H_E_STORE, H_E_RESTORE, H_M_LEVEL, H_SEL_MAN
  } amcal_hstate_t;

  typedef struct packed {
    amcal_hstate_t st;
    logic          req;
    logic          we;
    logic [5:0]    addr;
    logic [7:0]    wdata;
    logic [31:0]   cfg;
    logic [1:0]    op;
    logic          done;
    logic          first;
    logic [7:0]    result;
    logic [7:0]    meas;
    logic [7:0]    target;
    logic [7:0]    best;
    logic [7:0]    mask;
    logic [31:0]   prdata;
  } amcal_host_t;

  amcal_host_t q;
  amcal_host_t d;

  function automatic logic mapped(input logic [7:0] a);
    return a == HREG_CTRL || a == HREG_CFG || a == HREG_STATUS || a == HREG_RESULT;
  endfunction

  always_comb
  begin
    logic          acc;
    logic          a_we;
    logic [5:0]    a_addr;
    logic [7:0]    a_data;
    amcal_hstate_t a_next;
    logic [5:0]    ratio;
    logic [7:0]    nbest;
    acc    = 1'b1;
    a_we   = 1'b1;
    a_addr = REG_CMD;
    a_data = BYTE_ZERO;
    a_next = H_IDLE;
    ratio  = q.cfg[CFG_RATIO_LSB +: RATIO_W];
    nbest  = BYTE_ZERO;
    d = q;

    // APB: read data latched in setup, writes land in access
    if (PSEL && !PENABLE)
    begin
      d.prdata = 32'h0000_0000;
      case (PADDR)
        HREG_CTRL:   d.prdata = {30'h0000_0000, q.op};
        HREG_CFG:    d.prdata = q.cfg;
        HREG_STATUS: d.prdata = {30'h0000_0000, q.done, q.st != H_IDLE};
        HREG_RESULT: d.prdata = {16'h0000, q.meas, q.result};
        default:     d.prdata = 32'h0000_0000;
      endcase
    end
    if (PSEL && PENABLE && PWRITE)
    begin
      if (PADDR == HREG_CFG)
      begin
        d.cfg = PWDATA & CFG_MASK;
      end
      else if (PADDR == HREG_CTRL && q.st == H_IDLE && PWDATA[1:0] != OP_NONE)
      begin
        d.op = PWDATA[1:0];
        d.done = 1'b0;
        d.first = 1'b1;
        d.st = H_AUX;
      end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Access table per state
    case (q.st)
      H_AUX:
      begin
        a_addr = REG_AUX;
        a_data = {7'h00, q.cfg[CFG_AM_BIT]};
        a_next = q.op == OP_AUTO ? H_A_DEPTH : (q.op == OP_EXT ? H_E_NORM0 : H_M_LEVEL);
      end
      H_A_DEPTH:
      begin
        a_addr = REG_DEPTH_CTRL;
        // No antenna tuning in this pair, so nothing must run first
        a_data = {1'b0, ratio, 1'b0};
        a_next = H_A_TXON;
      end
      H_A_TXON:    begin a_addr = REG_OPCTL; a_data = 8'h01; a_next = H_A_CMD; end
      H_A_CMD:     begin a_data = CMD_CAL_DEPTH; a_next = H_A_WAIT; end
      H_A_READ:    begin a_we = 1'b0; a_addr = REG_DEPTH_DISP; a_next = H_IDLE; end
      H_E_NORM0:   begin a_addr = REG_NORM_LEVEL; a_next = H_E_TXON; end
      H_E_TXON:    begin a_addr = REG_OPCTL; a_data = 8'h01; a_next = H_E_CMD; end
      H_E_CMD:     begin a_data = CMD_MEASURE; a_next = H_E_WAIT; end
      H_E_READ:    begin a_we = 1'b0; a_addr = REG_ADC_OUT; a_next = H_E_TRY; end
      H_E_TRY:
      begin
        a_addr = REG_NORM_LEVEL;
        a_data = q.best | q.mask;
        a_next = H_E_CMD;
      end
      H_E_STORE:   begin a_addr = REG_MOD_LEVEL; a_data = q.best; a_next = H_E_RESTORE; end
      H_E_RESTORE: begin a_addr = REG_NORM_LEVEL; a_next = H_SEL_MAN; end
      H_M_LEVEL:
      begin
        a_addr = REG_MOD_LEVEL;
        a_data = q.cfg[CFG_LEVEL_LSB +: DATA_W];
        a_next = H_SEL_MAN;
      end
      H_SEL_MAN:
      begin
        a_addr = REG_DEPTH_CTRL;
        a_data = {1'b1, ratio, 1'b0};
        a_next = H_IDLE;
      end
      default:     acc = 1'b0;
    endcase

    if (q.st == H_A_WAIT && !LINK.busy)
    begin
      d.st = H_A_READ;
    end
    if (q.st == H_E_WAIT && !LINK.busy)
    begin
      d.st = H_E_READ;
    end

    if (acc && !q.req)
    begin
      d.req = 1'b1;
      d.we = a_we;
      d.addr = a_addr;
      d.wdata = a_data;
    end
    else if (acc && LINK.ack)
    begin
      d.req = 1'b0;
      d.st = a_next;
      if (a_next == H_IDLE)
      begin
        d.done = 1'b1;
      end
      if (q.st == H_A_READ)
      begin
        d.result = LINK.rdata;
      end
      if (q.st == H_E_STORE)
      begin
        d.result = q.best;
      end
      if (q.st == H_E_READ && q.first)
      begin
        // Divisor may exceed 1.98 here, for depths past 33 percent
        d.meas = LINK.rdata;
        d.target = amcal_target(LINK.rdata, q.cfg[CFG_FRAC_LSB +: DATA_W]);
        d.best = BYTE_ZERO;
        d.mask = SAR_FIRST_MASK;
        d.first = 1'b0;
      end
      else if (q.st == H_E_READ)
      begin
        nbest = LINK.rdata >= q.target ? (q.best | q.mask) : q.best;
        d.best = nbest;
        d.mask = q.mask >> 1;
        d.st = q.mask == SAR_LAST_MASK ? H_E_STORE : H_E_TRY;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign PRDATA     = q.prdata;
  assign PREADY     = 1'b1;
  assign PSLVERR    = PSEL && PENABLE && !mapped(PADDR);
  assign LINK.req   = q.req;
  assign LINK.we    = q.we;
  assign LINK.addr  = q.addr;
  assign LINK.wdata = q.wdata;

endmodule

// File: amcal_assertions.sv
/*
  Checker for the link between controller and device, and for the
  device's converter and driver outputs.
  Assumes one clock; instantiated by the bench beside the link.
*/
`timescale 1ns/1ps
module amcal_assertions (
  input wire logic                         CLK,
  input wire logic                         RESET_N,
  input wire logic                         req,
  input wire logic                         we,
  input wire logic [amcal_pkg::ADDR_W-1:0] addr,
  input wire logic [amcal_pkg::DATA_W-1:0] wdata,
  input wire logic                         ack,
  input wire logic                         busy,
  input wire logic                         MOD_IN,
  input wire logic                         ADC_START,
  input wire logic                         TX_ENABLE,
  input wire logic                         AM_VERSUS_OOK_SELECT,
  input wire logic [amcal_pkg::DATA_W-1:0] ANTENNA_DRIVER_ONE_SEG,
  input wire logic [amcal_pkg::DATA_W-1:0] ANTENNA_DRIVER_TWO_SEG
);
  import amcal_pkg::*;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  //////////////////////////////////////////////////////////////////////////////
  // Conversions started within one command
  logic [3:0] starts_q;
  logic [3:0] starts_d;

  always_comb
  begin
    starts_d = busy ? starts_q + {3'h0, ADC_START} : 4'h0;
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
      starts_q <= 4'h0;
    else
      starts_q <= starts_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  AST_ACK_ANSWER: assert property (req && !ack |=> ack)
    else $error("link request not answered in one cycle");
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("link acknowledge longer than one cycle");
  AST_REQ_HOLD: assert property (req && !ack |=> req && $stable(addr) && $stable(we)
                                 && $stable(wdata))
    else $error("link request changed before acknowledge");
  AST_SEG_PAIR: assert property (ANTENNA_DRIVER_ONE_SEG == ANTENNA_DRIVER_TWO_SEG)
    else $error("driver segment sets differ");
  AST_TX_BEFORE_ADC: assert property (ADC_START |-> TX_ENABLE && $past(TX_ENABLE))
    else $error("conversion started without carrier on");
  AST_ADC_IN_CMD: assert property (ADC_START |-> busy)
    else $error("conversion started outside a command");
  AST_SAR_COUNT: assert property ($fell(busy) |-> starts_q == 4'h1 || starts_q == 4'h9)
    else $error("wrong number of conversions in a command");
  AST_SAR_HOLD: assert property (busy && ADC_START |=> $stable(ANTENNA_DRIVER_ONE_SEG) [*2])
    else $error("driver strength moved during a conversion");
  // A register write or command taken this cycle may change the idle drive
  AST_OOK_OFF: assert property (!busy && !(req && !ack) && MOD_IN && !AM_VERSUS_OOK_SELECT
                                |=> ANTENNA_DRIVER_ONE_SEG == 8'h00)
    else $error("keyed carrier not switched off");
endmodule

// File: am_mod_depth_calibration_bench.sv
/*
  Bench for the calibration pair: APB master and A/D converter stand-in.
  Assumes package, link, both ends and checker compiled before it.
*/
`timescale 1ns/1ps
module am_mod_depth_calibration_bench;
  import amcal_pkg::*;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mod_in = 1'b0;
  logic        adc_done = 1'b0;
  logic [7:0]  adc_amp = 8'h00;
  logic [2:0]  adc_cnt = 3'h0;
  logic        adc_start;
  logic        tx_en;
  logic        am_sel;
  logic [7:0]  seg_one;
  logic [7:0]  seg_two;
  logic [31:0] rd;
  logic        er;
  int          failures = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [5:0]  ratios [3] = '{6'h00, 6'h0E, 6'h3F};

  amcal_link_if link ();

  amcal_host i_amcal_host (
    .CLK     (clk),
    .RESET_N (rst_n),
    .PSEL    (psel),
    .PENABLE (penable),
    .PWRITE  (pwrite),
    .PADDR   (paddr),
    .PWDATA  (pwdata),
    .PRDATA  (prdata),
    .PREADY  (pready),
    .PSLVERR (pslverr),
    .LINK    (link.controller)
  );

  amcal_device #(.SETTLE_CYC(4'h2)) i_amcal_device (
    .CLK                    (clk),
    .RESET_N                (rst_n),
    .LINK                   (link.device),
    .MOD_IN                 (mod_in),
    .ADC_DONE               (adc_done),
    .SENSE_AMPLITUDE        (adc_amp),
    .ADC_START              (adc_start),
    .TX_ENABLE              (tx_en),
    .AM_VERSUS_OOK_SELECT   (am_sel),
    .ANTENNA_DRIVER_ONE_SEG (seg_one),
    .ANTENNA_DRIVER_TWO_SEG (seg_two)
  );

  amcal_assertions i_amcal_assertions (
    .CLK                    (clk),
    .RESET_N                (rst_n),
    .req                    (link.req),
    .we                     (link.we),
    .addr                   (link.addr),
    .wdata                  (link.wdata),
    .ack                    (link.ack),
    .busy                   (link.busy),
    .MOD_IN                 (mod_in),
    .ADC_START              (adc_start),
    .TX_ENABLE              (tx_en),
    .AM_VERSUS_OOK_SELECT   (am_sel),
    .ANTENNA_DRIVER_ONE_SEG (seg_one),
    .ANTENNA_DRIVER_TWO_SEG (seg_two)
  );

  // Clock runs from the start: oscillator up before any command
  always #50 clk = ~clk;

  //////////////////////////////////////////////////////////////////////////////
  // Converter: amplitude follows enabled segments; garbage outside done
  always @(posedge clk)
  begin
    adc_done <= (adc_cnt == 3'h1);
    adc_amp  <= (adc_cnt == 3'h1) ? seg_one : ~seg_one;
    if (adc_start)
      adc_cnt <= 3'h3;
    else if (adc_cnt != 3'h0)
      adc_cnt <= adc_cnt - 3'h1;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      conclude();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Full drive 0xFF divided by 1 + frac/64, truncated
  function automatic logic [7:0] exp_level(input logic [7:0] frac);
    logic [15:0] q;
    q = (16'h00FF * 16'h0040) / (16'h0040 + {8'h00, frac});
    return q[7:0];
  endfunction

  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Carrier unmodulated while a sequence runs
  task automatic run(input logic [1:0] op);
    @(posedge clk);
    mod_in <= 1'b0;
    apb(1'b1, HREG_CTRL, {30'h0, op}, rd, er);
    rd = 32'h0000_0000;
    while (rd[STAT_DONE_BIT] !== 1'b1)
      apb(1'b0, HREG_STATUS, 32'h0000_0000, rd, er);
    chk32("status done", 32'h0000_0002, rd);
  endtask

  task automatic seg_chk(input logic m, input logic [7:0] exp);
    @(posedge clk);
    mod_in <= m;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk8("driver one", exp, seg_one);
    chk8("driver two", exp, seg_two);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    seg_chk(1'b0, 8'hFF);
    apb(1'b0, HREG_STATUS, 32'h0000_0000, rd, er);
    chk32("status", 32'h0000_0000, rd);
    apb(1'b0, 8'h10, 32'h0000_0000, rd, er);
    chk32("unmapped error", 32'h0000_0001, {31'h0, er});
    chk32("unmapped data", 32'h0000_0000, rd);
    foreach (ratios[i])
    begin
      apb(1'b1, HREG_CFG, {7'h00, 1'b1, 16'h0000, 2'b00, ratios[i]}, rd, er);
      run(OP_AUTO);
      apb(1'b0, HREG_RESULT, 32'h0000_0000, rd, er);
      chk32("auto level", {24'h00_0000, ~exp_level({2'b00, ratios[i]})}, rd & 32'h0000_00FF);
      seg_chk(1'b1, exp_level({2'b00, ratios[i]}));
      seg_chk(1'b0, 8'hFF);
    end
    apb(1'b1, HREG_CFG, {7'h00, 1'b1, 8'h3C, 8'h00, 2'b00, 6'h0E}, rd, er);
    run(OP_MANUAL);
    seg_chk(1'b1, 8'hC3);
    apb(1'b1, HREG_CFG, {7'h00, 1'b0, 8'h3C, 8'h00, 2'b00, 6'h0E}, rd, er);
    run(OP_MANUAL);
    seg_chk(1'b1, 8'h00);
    // Divisor three: deeper than the command can reach
    apb(1'b1, HREG_CFG, {7'h00, 1'b1, 8'h00, 8'h80, 2'b00, 6'h00}, rd, er);
    apb(1'b0, HREG_CFG, 32'h0000_0000, rd, er);
    chk32("config", 32'h0100_8000, rd);
    run(OP_EXT);
    apb(1'b0, HREG_RESULT, 32'h0000_0000, rd, er);
    chk32("external level", {24'h00_0000, ~exp_level(8'h80)}, rd & 32'h0000_00FF);
    chk32("external carrier", 32'h0000_FF00, rd & 32'h0000_FF00);
    seg_chk(1'b1, exp_level(8'h80));
    seg_chk(1'b0, 8'hFF);
    // Start with no operation is refused; last operation stays readable
    apb(1'b1, HREG_CTRL, 32'h0000_0000, rd, er);
    apb(1'b0, HREG_CTRL, 32'h0000_0000, rd, er);
    chk32("last op", {30'h0000_0000, OP_EXT}, rd);
    conclude();
  end
endmodule
